// File: logic/irq_expander_pkg.sv
// Constants and types shared by the interrupt expander files.
// Assumes a single 40 MHz clock domain and a synchronous active-high reset.
package irq_expander_pkg;
    // ==========================================================
    // Geometry
    localparam int unsigned SOURCES      = 96;
    localparam int unsigned GROUP_SIZE   = 8;
    localparam int unsigned GROUPS       = 12;
    localparam int unsigned SRC_IDX_W    = 7;
    localparam int unsigned SUB_IDX_W    = 3;
    localparam int unsigned VECTOR_W     = 22;
    // ==========================================================
    // Sources wired to peripherals on this device (low positions)
    localparam int unsigned USED_SOURCES = 43;
    localparam logic [SOURCES-1:0] USED_MASK =
        {{(SOURCES-USED_SOURCES){1'b0}}, {USED_SOURCES{1'b1}}};
    // ==========================================================
    // Vector fetch and context save takes this many cpu cycles
    localparam int unsigned FETCH_CYCLES = 8;
    localparam logic [3:0]  FETCH_LAST   = 4'(FETCH_CYCLES - 1);
    localparam logic [VECTOR_W-1:0] VECTOR_RESET = 22'h000000;
    // ==========================================================
    // Fetch sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FETCH = 3'b010,
        ST_DONE  = 3'b100
    } fetch_state_t;
endpackage

// File: logic/irq_vector_ram.sv
// Vector RAM: one entry per interrupt source, software writable at any time.
// Assumes writes and reads on the same clock; read has one cycle latency.
`timescale 1ns/1ps
`default_nettype none
module irq_vector_ram #(
    parameter int unsigned DEPTH  = 96,
    parameter int unsigned AW     = 7,
    parameter int unsigned DW     = 22
) (
    input  wire logic          clk_in,     // Clock
    input  wire logic          we_in,      // Write strobe
    input  wire logic [AW-1:0] waddr_in,   // Write index
    input  wire logic [DW-1:0] wdata_in,   // Write data
    input  wire logic [AW-1:0] raddr_in,   // Read index
    output var  logic [DW-1:0] rdata_out   // Registered read data
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge clk_in) begin
        if (we_in && (32'(waddr_in) < DEPTH)) begin
            mem[waddr_in] <= wdata_in;
        end
        rdata_out <= mem[raddr_in];
    end
endmodule // irq_vector_ram
`default_nettype wire

// File: logic/peripheral_interrupt_expander.sv
// Interrupt expander: latches 96 sources, gates them, drives 12 cpu lines
// and delivers the vector of the winning source on acknowledge.
// Assumes peripheral requests are pulses or levels from the same clock.
//
// Summary of operation
// - Up to 96 peripheral requests are funnelled onto fewer cpu lines.
// - Sources form groups of eight, each group driving one of twelve lines.
// - Every source has its own vector in software-writable RAM.
// - On service the winner's vector is fetched, done in 8 clock cycles.
// - Each source has an enable; a disabled source never raises its line.
// - Only 43 positions are connected; the rest never request.
//
// Hazards and limits
// - Requests are sampled with no synchroniser, so every source must come
//   from logic on this clock; an asynchronous source needs its own pair
//   of flip-flops in front of this block.
// - A request that arrives in the very cycle its own flag is serviced is
//   kept: the set wins over the clear and the line rises again after the
//   fetch, so no event is lost to an unlucky acknowledge.
// - Acknowledges while a fetch runs are dropped silently; the cpu side
//   must wait for the vector pulse before it services the next line.
// - The vector RAM has no reset; software must fill every entry that it
//   enables before the first service, or the fetched vector is unknown.
// - Dropping an enable hides a pending request but does not clear it, so
//   the line comes back as soon as the enable returns.
// - The serviced line is held low for the whole fetch so that the cpu
//   cannot take the same group twice for one request.
// - A vector written during a fetch is seen by that fetch only if the
//   write lands before the last fetch cycle; later writes take effect
//   on the next service of that source.
// - Lines rise two edges after a request: one edge to latch the flag
//   and one to register the line, traded for a clean flip-flop output.
`timescale 1ns/1ps
`default_nettype none
module peripheral_interrupt_expander #(
    parameter int unsigned SOURCES  = irq_expander_pkg::SOURCES,
    parameter int unsigned GROUPS   = irq_expander_pkg::GROUPS,
    parameter int unsigned VECTOR_W = irq_expander_pkg::VECTOR_W
) (
    input  wire logic                ref_clk_in,     // 40 MHz clock
    input  wire logic                sys_rst_in,     // Sync reset, high
    input  wire logic [SOURCES-1:0]  periph_irq_in,  // Source requests
    input  wire logic [SOURCES-1:0]  src_enable_in,  // Per-source enable
    input  wire logic                vec_we_in,      // Vector write strobe
    input  wire logic [6:0]          vec_waddr_in,   // Vector write index
    input  wire logic [VECTOR_W-1:0] vec_wdata_in,   // Vector write data
    input  wire logic                cpu_ack_in,     // CPU services a line
    input  wire logic [3:0]          cpu_ack_line_in,// Line index 0..11
    output var  logic [GROUPS-1:0]   cpu_irq_out,    // Lines first..last
    output var  logic                vec_valid_out,  // Vector ready pulse
    output var  logic [VECTOR_W-1:0] vec_out,        // Fetched vector
    output var  logic [6:0]          vec_src_out,    // Winning source
    output var  logic                fetch_busy_out  // Fetch in progress
);
    localparam int unsigned GS = irq_expander_pkg::GROUP_SIZE;

    typedef struct packed {
        logic [SOURCES-1:0]             pend;
        logic [GROUPS-1:0]              irq;
        irq_expander_pkg::fetch_state_t st;
        logic [3:0]                     cnt;
        logic [6:0]                     src;
        logic                           vvalid;
        logic [VECTOR_W-1:0]            vec;
        logic                           busy;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [VECTOR_W-1:0] ram_rdata;
    logic [SOURCES-1:0]  live;
    logic [GROUPS-1:0]   grp_req;
    logic [2:0]          grp_win [GROUPS];
    logic                ack_ok;
    logic [SOURCES-1:0]  pend_set;

    // Lowest-numbered set bit of an 8-bit group
    function automatic logic [2:0] first_set(input logic [GS-1:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = GS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // Acknowledge counts only for a real line with an enabled pending
    // source behind it; anything else is ignored without a trace
    function automatic logic ack_valid(
        input logic              ack,
        input logic [3:0]        line,
        input logic [GROUPS-1:0] req
    );
        logic ok;
        ok = 1'b0;
        if (ack && (32'(line) < GROUPS)) begin
            ok = req[line];
        end
        return ok;
    endfunction

    // ==========================================================
    // Request capture
    // Unused positions are masked at the input so that they can never
    // latch a flag, whatever the peripheral side does with them
    genvar p;
    generate
        for (p = 0; p < SOURCES; p++) begin : g_src
            assign pend_set[p] = periph_irq_in[p]
                                 & irq_expander_pkg::USED_MASK[p];
        end
    endgenerate

    // ==========================================================
    // Request gating
    assign live = s_q.pend & src_enable_in
                  & irq_expander_pkg::USED_MASK;

    genvar g;
    generate
        for (g = 0; g < GROUPS; g++) begin : g_grp
            assign grp_req[g] = |live[g*GS +: GS];
            assign grp_win[g] = first_set(live[g*GS +: GS]);
        end
    endgenerate

    irq_vector_ram #(
        .DEPTH (SOURCES),
        .AW    (7),
        .DW    (VECTOR_W)
    ) u_ram (
        .clk_in    (ref_clk_in),
        .we_in     (vec_we_in),
        .waddr_in  (vec_waddr_in),
        .wdata_in  (vec_wdata_in),
        .raddr_in  (s_q.src),
        .rdata_out (ram_rdata)
    );

    // ==========================================================
    // Acknowledge decode
    assign ack_ok = ack_valid(cpu_ack_in, cpu_ack_line_in, grp_req);

    // ==========================================================
    // Next state
    always_comb begin
        logic [2:0]    sub;
        s_d = s_q;
        sub = 3'h0;
        s_d.vvalid = 1'b0;
        s_d.pend = s_q.pend | pend_set;
        unique case (s_q.st)
            irq_expander_pkg::ST_IDLE: begin
                if (ack_ok) begin
                    sub = grp_win[cpu_ack_line_in];
                    s_d.src = 7'({cpu_ack_line_in, sub});
                    // Clear only the serviced flag; a request on that
                    // same source in this cycle sets it again (set wins)
                    s_d.pend[{cpu_ack_line_in, sub}] =
                        pend_set[{cpu_ack_line_in, sub}];
                    s_d.cnt = 4'h0;
                    s_d.busy = 1'b1;
                    s_d.st = irq_expander_pkg::ST_FETCH;
                end
            end
            irq_expander_pkg::ST_FETCH: begin
                // Seven fetch cycles plus the done cycle keep busy up
                // for exactly the documented number of edges
                s_d.cnt = s_q.cnt + 4'h1;
                if (s_q.cnt == irq_expander_pkg::FETCH_LAST - 4'h1) begin
                    s_d.st = irq_expander_pkg::ST_DONE;
                end
            end
            irq_expander_pkg::ST_DONE: begin
                // RAM data for src has been stable for many cycles
                s_d.vec = ram_rdata;
                s_d.vvalid = 1'b1;
                s_d.busy = 1'b0;
                s_d.st = irq_expander_pkg::ST_IDLE;
            end
            default: begin
                s_d.st = irq_expander_pkg::ST_IDLE;
                s_d.busy = 1'b0;
            end
        endcase
        s_d.irq = grp_req;
        // A line being serviced is held low so it is not re-taken
        if (s_d.busy) begin
            s_d.irq[s_d.src[6:3]] = 1'b0;
        end
    end

    // ==========================================================
    // State register
    // The vector RAM is left out of reset on purpose: it is software's
    // table and clearing 96 words would cost a wide reset tree
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            s_q.pend   <= '0;
            s_q.irq    <= '0;
            s_q.st     <= irq_expander_pkg::ST_IDLE;
            s_q.cnt    <= 4'h0;
            s_q.src    <= 7'h00;
            s_q.vvalid <= 1'b0;
            s_q.vec    <= irq_expander_pkg::VECTOR_RESET;
            s_q.busy   <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end


    // ==========================================================
    // Outputs, all straight from the state register
    assign cpu_irq_out    = s_q.irq;
    assign vec_valid_out  = s_q.vvalid;
    assign vec_out        = s_q.vec;
    assign vec_src_out    = s_q.src;
    assign fetch_busy_out = s_q.busy;
endmodule // peripheral_interrupt_expander
`default_nettype wire

// File: tb/irq_expander_assertions.sv
// Checker for the interrupt expander, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module irq_expander_assertions #(
    parameter int unsigned SOURCES  = 96,
    parameter int unsigned GROUPS   = 12,
    parameter int unsigned VECTOR_W = 22
) (
    input wire logic                ref_clk_in,      // Clock
    input wire logic                sys_rst_in,      // Reset
    input wire logic [SOURCES-1:0]  src_enable_in,   // Enables
    input wire logic                cpu_ack_in,      // Ack
    input wire logic [3:0]          cpu_ack_line_in, // Ack line
    input wire logic [GROUPS-1:0]   cpu_irq_out,     // Lines
    input wire logic                vec_valid_out,   // Vector pulse
    input wire logic [VECTOR_W-1:0] vec_out,         // Vector
    input wire logic [6:0]          vec_src_out,     // Winner
    input wire logic                fetch_busy_out   // Busy
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    AST_UNUSED_LINES: assert property (cpu_irq_out[11:6] == 6'h00)
        else $error("unused group line high");
    AST_DISABLED_QUIET: assert property ($past(src_enable_in) == '0 &&
        $past(src_enable_in, 2) == '0 |-> cpu_irq_out == '0)
        else $error("line high with all sources off");
    AST_FETCH_LEN: assert property ($rose(fetch_busy_out) |->
        fetch_busy_out [*8] ##1 (vec_valid_out && !fetch_busy_out))
        else $error("fetch not eight cycles");
    AST_NO_STRAY_FETCH: assert property (!fetch_busy_out &&
        !(cpu_ack_in && cpu_ack_line_in < 4'hC) |=> !fetch_busy_out)
        else $error("fetch without valid ack");
    AST_VALID_PULSE: assert property (vec_valid_out |=> !vec_valid_out)
        else $error("valid longer than one cycle");
    AST_SRC_HOLD: assert property (!$past(sys_rst_in) &&
        !$rose(fetch_busy_out) |-> $stable(vec_src_out))
        else $error("winner changed outside fetch start");
    AST_VEC_HOLD: assert property (!$past(sys_rst_in) &&
        !vec_valid_out |-> $stable(vec_out))
        else $error("vector changed without valid");
    AST_SRC_GROUP: assert property ($rose(fetch_busy_out) |->
        vec_src_out[6:3] == $past(cpu_ack_line_in) && vec_src_out < 7'h2B)
        else $error("winner outside serviced group");
endmodule // irq_expander_assertions
bind peripheral_interrupt_expander irq_expander_assertions #(
    .SOURCES(SOURCES), .GROUPS(GROUPS), .VECTOR_W(VECTOR_W)) i_chk (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .src_enable_in(src_enable_in), .cpu_ack_in(cpu_ack_in),
    .cpu_ack_line_in(cpu_ack_line_in), .cpu_irq_out(cpu_irq_out),
    .vec_valid_out(vec_valid_out), .vec_out(vec_out),
    .vec_src_out(vec_src_out), .fetch_busy_out(fetch_busy_out));
`default_nettype wire

// File: tb/cpu_core_model.sv
// CPU side model: services raised lines, lowest line first.
// Assumes expander outputs settle by the falling edge.
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
    input  wire logic        clk_in,   // Clock
    input  wire logic        auto_in,  // Service enable
    input  wire logic [3:0]  wait_in,  // Answer delay
    input  wire logic [11:0] irq_in,   // Cpu lines
    output var  logic        ack_out,  // Service pulse
    output var  logic [3:0]  line_out  // Serviced line
);
    initial begin
        ack_out = 1'b0;
        line_out = 4'hF;
        forever begin
            @(negedge clk_in);
            if (auto_in && irq_in != 12'h000) begin
                repeat (wait_in) @(negedge clk_in);
                for (int i = 11; i >= 0; i--)
                    if (irq_in[i]) line_out = 4'(i);
                ack_out = 1'b1;
                @(negedge clk_in);
                ack_out = 1'b0;
                line_out = 4'hF;
                // Next service only after the vector fetch
                repeat (9) @(negedge clk_in);
            end
        end
    end
endmodule // cpu_core_model
`default_nettype wire

// File: tb/tb_peripheral_interrupt_expander.sv
// Testbench for the interrupt expander with a cpu model on its lines.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
module tb_peripheral_interrupt_expander;
    logic ref_clk_in = 1'b0, sys_rst_in = 1'b1, we = 1'b0, auto = 1'b0;
    logic tb_ack = 1'b0, m_ack, vld, busy;
    logic [3:0] tb_line = 4'hF, m_line;
    logic [95:0] irq = '0, en = '0;
    logic [6:0] waddr = '0, src;
    logic [21:0] wdata = '0, vec;
    logic [11:0] lines;
    int miscompares = 0, checks_done = 0, cycles = 0;
    peripheral_interrupt_expander i_dut (.ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in), .periph_irq_in(irq), .src_enable_in(en),
        .vec_we_in(we), .vec_waddr_in(waddr), .vec_wdata_in(wdata),
        .cpu_ack_in(auto ? m_ack : tb_ack),
        .cpu_ack_line_in(auto ? m_line : tb_line), .cpu_irq_out(lines),
        .vec_valid_out(vld), .vec_out(vec), .vec_src_out(src),
        .fetch_busy_out(busy));
    cpu_core_model i_cpu (.clk_in(ref_clk_in), .auto_in(auto),
        .wait_in(4'h5), .irq_in(lines), .ack_out(m_ack), .line_out(m_line));
    initial forever #12.5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end
    function automatic logic [21:0] vec_of(input int s);
        return {15'h1D2C, 7'(s)};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask
    task automatic check(input logic [21:0] seen, input logic [21:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
        end
    endtask
    task automatic raise(input logic [95:0] m);
        tick(1);
        irq = m;
        tick(1);
        irq = '0;
        tick(2);
    endtask
    task automatic ack(input logic [3:0] ln);
        tick(1);
        tb_ack = 1'b1;
        tb_line = ln;
        tick(1);
        tb_ack = 1'b0;
        tb_line = 4'hF;
    endtask
    task automatic serve(input logic [3:0] ln, input int s);
        int k;
        ack(ln);
        for (k = 0; k < 12 && vld !== 1'b1; k++) tick(1);
        check(22'(k), 22'h8);
        check(22'(src), 22'(s));
        check(vec, vec_of(s));
    endtask
    task automatic refused(input logic [3:0] ln);
        ack(ln);
        tick(1);
        check(22'(busy), 22'h0);
    endtask
    task automatic t_group;
        en = '1;
        raise(96'h1000040000000028);
        check(22'(lines), 22'h021);
        serve(4'h0, 3);
        serve(4'h0, 5);
        serve(4'h5, 42);
        tick(2);
        check(22'(lines), 22'h0);
        $display("test group done");
    endtask
    task automatic t_enable;
        en[10] = 1'b0;
        raise(96'h400);
        check(22'(lines), 22'h0);
        refused(4'h1);
        refused(4'hC);
        en[10] = 1'b1;
        tick(2);
        check(22'(lines), 22'h002);
        serve(4'h1, 10);
        $display("test enable done");
    endtask
    task automatic t_collide;
        raise(96'h100000);
        tick(1);
        irq[20] = 1'b1;
        tb_ack = 1'b1;
        tb_line = 4'h2;
        tick(1);
        irq = '0;
        tb_ack = 1'b0;
        tb_line = 4'hF;
        tick(10);
        check(22'(lines), 22'h004);
        we = 1'b1;
        waddr = 7'h14;
        wdata = 22'h2A5A5A;
        tick(1);
        we = 1'b0;
        ack(4'h2);
        tick(8);
        check(22'(vld), 22'h1);
        check(vec, 22'h2A5A5A);
        check(22'(src), 22'h14);
        $display("test collide done");
    endtask
    task automatic t_cpu;
        auto = 1'b1;
        raise(96'h200020201);
        tick(80);
        check(22'(lines), 22'h0);
        check(22'(src), 22'h21);
        check(vec, vec_of(33));
        auto = 1'b0;
        $display("test cpu done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        tick(4);
        sys_rst_in = 1'b0;
        check(22'({lines, busy, vld}), 22'h0);
        we = 1'b1;
        for (int s = 0; s < 96; s++) begin
            waddr = 7'(s);
            wdata = vec_of(s);
            tick(1);
        end
        we = 1'b0;
        t_group();
        t_enable();
        t_collide();
        t_cpu();
        report_and_stop();
    end
endmodule // tb_peripheral_interrupt_expander
`default_nettype wire
